// ==== clk_cfg_pkg.sv ====
// Constants shared by the clock mode configuration decoder and its mode table.
// Assumes one 25 MHz clock and an APB master with 32-bit data.
package clk_cfg_pkg;
  // Widths of the mode code, factor, divider and address fields
  localparam int MODE_W = 7;
  localparam int FACTOR_W = 5;
  localparam int DIV_W = 4;
  localparam int ADDR_W = 8;
  // Positions inside the hard reset configuration word
  localparam int RANGE_BIT_POS = 27;
  localparam int MODE_HIGH_LSB = 28;
  localparam int MODE_HIGH_MSB = 31;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] FACTOR_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 8'h08;
  // Status register field positions
  localparam int ST_AGENT_POS = 0;
  localparam int ST_RANGE_POS = 1;
  localparam int ST_REF_PCI_POS = 2;
  localparam int ST_RESERVED_POS = 3;
  localparam int ST_VALID_POS = 4;
  localparam int ST_CAPTURED_POS = 5;
  localparam int ST_MODE_LSB = 8;
  // Factor register field positions
  localparam int FA_COMM_LSB = 0;
  localparam int FA_CPU_LSB = 8;
  localparam int FA_DIV_LSB = 16;
  localparam int FA_RATIO_LSB = 24;
  // Control register field position and values after reset
  localparam int CTL_TICK_EN_POS = 0;
  localparam logic CTL_TICK_EN_RESET = 1'b1;
  localparam logic [MODE_W-1:0] MODE_CODE_RESET = 7'h00;
  localparam logic [FACTOR_W-1:0] FACTOR_RESET = 5'h00;
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // Divider field codes and the clock ratios they stand for
  localparam logic [DIV_W-1:0] DIV_FIELD_3 = 4'h3;
  localparam logic [DIV_W-1:0] DIV_FIELD_5 = 4'h5;
  localparam logic [DIV_W-1:0] DIV_FIELD_7 = 4'h7;
  localparam logic [DIV_W-1:0] DIV_FIELD_9 = 4'h9;
  localparam logic [DIV_W-1:0] DIV_FIELD_B = 4'hb;
  localparam logic [DIV_W-1:0] RATIO_4 = 4'h4;
  localparam logic [DIV_W-1:0] RATIO_5 = 4'h5;
  localparam logic [DIV_W-1:0] RATIO_6 = 4'h6;
  localparam logic [DIV_W-1:0] RATIO_8 = 4'h8;
  // Configuration capture states
  typedef enum logic [2:0] {
    ST_UNCONF = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_RUN = 3'b100
  } cfg_state_t;
endpackage : clk_cfg_pkg

// ==== mode_table.sv ====
// Host mode table for the 25-50 MHz PCI range: mode code to factors.
// Assumes the caller only trusts it in host mode with the range bit at 1.
`timescale 1ns/1ns
module mode_table (
  input wire logic [clk_cfg_pkg::MODE_W-1:0] code,
  output logic [clk_cfg_pkg::FACTOR_W-1:0] comm_x2,
  output logic [clk_cfg_pkg::FACTOR_W-1:0] cpu_x2,
  output logic [clk_cfg_pkg::DIV_W-1:0] div_field,
  output logic reserved
);
  import clk_cfg_pkg::*;

  // One entry: twice the comm factor, twice the CPU factor, divider field
  logic [2*FACTOR_W+DIV_W-1:0] entry;

  // Factors are kept at twice their value so that half steps are exact
  always_comb begin
    reserved = 1'b0;
    entry = {5'h00, 5'h00, 4'h0};
    case (code)
      7'h00: entry = {5'h04, 5'h05, 4'h3};
      7'h01: entry = {5'h04, 5'h06, 4'h3};
      7'h02: entry = {5'h05, 5'h06, 4'h5};
      7'h03: entry = {5'h05, 5'h07, 4'h5};
      7'h04: entry = {5'h05, 5'h08, 4'h5};
      7'h05: entry = {5'h06, 5'h06, 4'h5};
      7'h06: entry = {5'h06, 5'h07, 4'h5};
      7'h07: entry = {5'h06, 5'h08, 4'h5};
      7'h08: entry = {5'h06, 5'h0a, 4'h5};
      7'h09: entry = {5'h06, 5'h0c, 4'h5};
      7'h0a: entry = {5'h06, 5'h0e, 4'h5};
      7'h0b: entry = {5'h06, 5'h10, 4'h5};
      7'h10: entry = {5'h08, 5'h0a, 4'h7};
      7'h11: entry = {5'h08, 5'h0c, 4'h7};
      7'h12: entry = {5'h08, 5'h0e, 4'h7};
      7'h13: entry = {5'h08, 5'h10, 4'h7};
      7'h14: entry = {5'h08, 5'h0a, 4'h5};
      7'h15: entry = {5'h08, 5'h0b, 4'h5};
      7'h16: entry = {5'h08, 5'h0c, 4'h5};
      7'h18: entry = {5'h0a, 5'h0a, 4'h9};
      7'h19: entry = {5'h0a, 5'h0c, 4'h9};
      7'h1a: entry = {5'h0a, 5'h0e, 4'h9};
      7'h1b: entry = {5'h0a, 5'h10, 4'h9};
      7'h21: entry = {5'h0c, 5'h0c, 4'h5};
      7'h22: entry = {5'h0c, 5'h0e, 4'h5};
      7'h23: entry = {5'h0c, 5'h10, 4'h5};
      7'h28: entry = {5'h04, 5'h05, 4'h3};
      7'h29: entry = {5'h04, 5'h06, 4'h3};
      7'h2a: entry = {5'h04, 5'h07, 4'h3};
      7'h2b: entry = {5'h04, 5'h08, 4'h3};
      7'h2c: entry = {5'h04, 5'h09, 4'h3};
      7'h2d: entry = {5'h06, 5'h07, 4'h9};
      7'h2e: entry = {5'h06, 5'h08, 4'h9};
      7'h2f: entry = {5'h06, 5'h09, 4'h9};
      7'h30: entry = {5'h05, 5'h05, 4'h5};
      7'h31: entry = {5'h05, 5'h06, 4'h5};
      7'h32: entry = {5'h05, 5'h07, 4'h5};
      7'h33: entry = {5'h05, 5'h08, 4'h5};
      7'h34: entry = {5'h05, 5'h09, 4'h5};
      7'h35: entry = {5'h05, 5'h0a, 4'h5};
      7'h36: entry = {5'h05, 5'h0c, 4'h5};
      7'h39: entry = {5'h06, 5'h06, 4'h5};
      7'h3a: entry = {5'h06, 5'h07, 4'h5};
      7'h3b: entry = {5'h06, 5'h08, 4'h5};
      7'h3c: entry = {5'h06, 5'h09, 4'h5};
      7'h41: entry = {5'h06, 5'h06, 4'h7};
      7'h42: entry = {5'h06, 5'h07, 4'h7};
      7'h43: entry = {5'h06, 5'h08, 4'h7};
      7'h44: entry = {5'h06, 5'h09, 4'h7};
      7'h45: entry = {5'h06, 5'h0c, 4'h7};
      7'h46: entry = {5'h06, 5'h0d, 4'h7};
      7'h4a: entry = {5'h07, 5'h07, 4'h7};
      7'h4b: entry = {5'h07, 5'h08, 4'h7};
      7'h4c: entry = {5'h07, 5'h09, 4'h7};
      7'h4d: entry = {5'h07, 5'h0a, 4'h5};
      7'h4e: entry = {5'h07, 5'h0b, 4'h5};
      7'h4f: entry = {5'h07, 5'h0c, 4'h5};
      7'h50: entry = {5'h04, 5'h04, 4'h5};
      7'h51: entry = {5'h04, 5'h05, 4'h5};
      7'h52: entry = {5'h04, 5'h06, 4'h5};
      7'h53: entry = {5'h04, 5'h07, 4'h5};
      7'h54: entry = {5'h04, 5'h08, 4'h5};
      7'h55: entry = {5'h04, 5'h05, 4'h7};
      7'h56: entry = {5'h04, 5'h06, 4'h7};
      7'h57: entry = {5'h04, 5'h07, 4'h7};
      7'h59: entry = {5'h05, 5'h05, 4'h7};
      7'h5a: entry = {5'h05, 5'h06, 4'h7};
      7'h5b: entry = {5'h05, 5'h07, 4'h7};
      7'h5c: entry = {5'h05, 5'h08, 4'h7};
      default: reserved = 1'b1; // Codes with no entry are reserved
    endcase
    {comm_x2, cpu_x2, div_field} = entry;
  end
endmodule : mode_table

// ==== clock_mode_config_decoder.sv ====
// Clock mode configuration decoder with an APB register view.
// Assumes straps and configuration word are steady while power-on reset is low.
//
// Contract
// - Host-enable strap 0 selects host clocking, 1 selects agent clocking.
// - Range-select bit is configuration word bit 27.
// - Range-select 0 means 50-66 MHz PCI range, 1 means 25-50 MHz.
// - Seven-bit mode code: word bits 28-31 high, three straps low.
// - Clock configuration changes only while power-on reset is asserted.
// - Host mode: bus clock is reference, PCI clock is comm clock divided.
// - Range 1: divider field 3,5,7,9,B gives ratio 4,6,8,5,6.
// - Agent mode: PCI clock is the PLL reference.
`timescale 1ns/1ns
module clock_mode_config_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_on_reset_input_n,
  input wire logic host_enable_strap,
  input wire logic [31:0] config_word,
  input wire logic [2:0] low_mode_straps,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clk_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic clocking_agent_mode,
  output logic pci_range_select_bit,
  output logic pll_ref_is_pci,
  output logic [clk_cfg_pkg::MODE_W-1:0] mode_code,
  output logic mode_reserved,
  output logic table_valid,
  output logic [clk_cfg_pkg::FACTOR_W-1:0] comm_mult_x2,
  output logic [clk_cfg_pkg::FACTOR_W-1:0] cpu_mult_x2,
  output logic [clk_cfg_pkg::DIV_W-1:0] pci_divider_field,
  output logic [clk_cfg_pkg::DIV_W-1:0] pci_clock_ratio,
  output logic pci_clock_tick
);
  import clk_cfg_pkg::*;

  cfg_state_t state, next_state;
  logic next_agent, next_range, next_ref_pci;
  logic [MODE_W-1:0] next_mode_code;
  logic [FACTOR_W-1:0] lut_comm, lut_cpu;
  logic [DIV_W-1:0] lut_div_field;
  logic lut_reserved;
  logic [FACTOR_W-1:0] next_comm, next_cpu;
  logic [DIV_W-1:0] next_div_field, next_ratio;
  logic next_reserved, next_valid;
  logic tick_en, next_tick_en;
  logic [DIV_W-1:0] tick_count, next_tick_count;
  logic next_tick;
  logic [31:0] next_prdata, status_word, factor_word;
  logic next_pready, next_pslverr;
  logic mapped;

  mode_table mode_table_i (
    .code(mode_code),
    .comm_x2(lut_comm),
    .cpu_x2(lut_cpu),
    .div_field(lut_div_field),
    .reserved(lut_reserved)
  );

  // Capture of straps and word while power-on reset is held low
  always_comb begin
    next_state = state;
    next_agent = clocking_agent_mode;
    next_range = pci_range_select_bit;
    next_ref_pci = pll_ref_is_pci;
    next_mode_code = mode_code;
    case (state)
      ST_UNCONF, ST_RUN: begin
        if (!power_on_reset_input_n) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (power_on_reset_input_n) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_UNCONF;
    endcase
    if (!power_on_reset_input_n) begin
      next_agent = host_enable_strap;
      next_range = config_word[RANGE_BIT_POS];
      next_ref_pci = host_enable_strap;
      next_mode_code = {config_word[MODE_HIGH_MSB:MODE_HIGH_LSB], low_mode_straps};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_UNCONF;
      clocking_agent_mode <= 1'b0;
      pci_range_select_bit <= 1'b0;
      pll_ref_is_pci <= 1'b0;
      mode_code <= MODE_CODE_RESET;
    end else begin
      state <= next_state;
      clocking_agent_mode <= next_agent;
      pci_range_select_bit <= next_range;
      pll_ref_is_pci <= next_ref_pci;
      mode_code <= next_mode_code;
    end
  end

  // Factor decode; the table only covers host clocking in the 25-50 MHz range
  always_comb begin
    next_valid = !clocking_agent_mode && pci_range_select_bit && !lut_reserved;
    next_reserved = lut_reserved;
    next_comm = lut_comm;
    next_cpu = lut_cpu;
    next_div_field = lut_div_field;
    next_ratio = DIV_RESET;
    if (pci_range_select_bit) begin
      case (lut_div_field)
        DIV_FIELD_3: next_ratio = RATIO_4;
        DIV_FIELD_5: next_ratio = RATIO_6;
        DIV_FIELD_7: next_ratio = RATIO_8;
        DIV_FIELD_9: next_ratio = RATIO_5;
        DIV_FIELD_B: next_ratio = RATIO_6;
        default: next_ratio = DIV_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      table_valid <= 1'b0;
      mode_reserved <= 1'b0;
      comm_mult_x2 <= FACTOR_RESET;
      cpu_mult_x2 <= FACTOR_RESET;
      pci_divider_field <= DIV_RESET;
      pci_clock_ratio <= DIV_RESET;
    end else begin
      table_valid <= next_valid;
      mode_reserved <= next_reserved;
      comm_mult_x2 <= next_comm;
      cpu_mult_x2 <= next_cpu;
      pci_divider_field <= next_div_field;
      pci_clock_ratio <= next_ratio;
    end
  end

  // PCI clock tick: clk stands in for the comm clock, divided by the ratio
  always_comb begin
    next_tick_count = DIV_RESET;
    next_tick = 1'b0;
    if (tick_en && table_valid && state == ST_RUN && pci_clock_ratio != DIV_RESET) begin
      if (tick_count >= DIV_W'(pci_clock_ratio - 4'h1)) begin
        next_tick = 1'b1;
      end else begin
        next_tick_count = DIV_W'(tick_count + 4'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_count <= DIV_RESET;
      pci_clock_tick <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      pci_clock_tick <= next_tick;
    end
  end

  // APB slave: read data and ready are loaded in the setup cycle
  always_comb begin
    status_word = READ_ZERO;
    status_word[ST_AGENT_POS] = clocking_agent_mode;
    status_word[ST_RANGE_POS] = pci_range_select_bit;
    status_word[ST_REF_PCI_POS] = pll_ref_is_pci;
    status_word[ST_RESERVED_POS] = mode_reserved;
    status_word[ST_VALID_POS] = table_valid;
    status_word[ST_CAPTURED_POS] = (state == ST_RUN);
    status_word[ST_MODE_LSB +: MODE_W] = mode_code;
    factor_word = READ_ZERO;
    factor_word[FA_COMM_LSB +: FACTOR_W] = comm_mult_x2;
    factor_word[FA_CPU_LSB +: FACTOR_W] = cpu_mult_x2;
    factor_word[FA_DIV_LSB +: DIV_W] = pci_divider_field;
    factor_word[FA_RATIO_LSB +: DIV_W] = pci_clock_ratio;
    mapped = (paddr == STATUS_OFFSET) || (paddr == FACTOR_OFFSET) || (paddr == CONTROL_OFFSET);
    next_prdata = READ_ZERO;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_tick_en = tick_en;
    if (psel && !penable) begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      if (!pwrite) begin
        case (paddr)
          STATUS_OFFSET: next_prdata = status_word;
          FACTOR_OFFSET: next_prdata = factor_word;
          CONTROL_OFFSET: next_prdata = {31'h0000_0000, tick_en};
          default: next_prdata = READ_ZERO;
        endcase
      end
    end
    if (psel && penable && pready && pwrite && paddr == CONTROL_OFFSET) begin
      next_tick_en = pwdata[CTL_TICK_EN_POS];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= READ_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tick_en <= CTL_TICK_EN_RESET;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      tick_en <= next_tick_en;
    end
  end

  // Checking helpers: cycles since the previous tick
  logic [DIV_W-1:0] gap;
  logic gap_armed;
  always_ff @(posedge clk) begin
    if (rst || !power_on_reset_input_n || $changed(pci_clock_ratio) || !tick_en) begin
      gap <= 4'h1;
      gap_armed <= 1'b0;
    end else if (pci_clock_tick) begin
      gap <= 4'h1;
      gap_armed <= 1'b1;
    end else if (gap != 4'hf) begin
      gap <= DIV_W'(gap + 4'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_agent_sel;
    !power_on_reset_input_n |=> clocking_agent_mode == $past(host_enable_strap);
  endproperty
  a_agent_sel: assert property (p_agent_sel) else $error("clocking mode not taken from strap");
  property p_range_bit;
    !power_on_reset_input_n |=> pci_range_select_bit == $past(config_word[27]);
  endproperty
  a_range_bit: assert property (p_range_bit) else $error("range bit not word bit 27");
  property p_range_table;
    table_valid |-> $past(pci_range_select_bit) && !$past(clocking_agent_mode) && !mode_reserved;
  endproperty
  a_range_table: assert property (p_range_table) else $error("table used outside its range");
  property p_mode_code;
    !power_on_reset_input_n |=> mode_code == {$past(config_word[31:28]), $past(low_mode_straps)};
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("mode code capture wrong");
  property p_hold;
    power_on_reset_input_n && $past(power_on_reset_input_n) && !$past(rst)
      |-> $stable(mode_code) && $stable(clocking_agent_mode) && $stable(pci_range_select_bit);
  endproperty
  a_hold: assert property (p_hold) else $error("configuration changed outside power-on reset");
  property p_tick_gap;
    pci_clock_tick && gap_armed |-> gap == pci_clock_ratio;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("PCI tick spacing not the ratio");
  property p_ratio;
    $past(pci_range_select_bit) && pci_divider_field == 4'h9 |-> pci_clock_ratio == 4'h5;
  endproperty
  a_ratio: assert property (p_ratio) else $error("divider 9 not ratio 5");
  property p_ref_pci;
    !power_on_reset_input_n ##1 power_on_reset_input_n |-> pll_ref_is_pci == clocking_agent_mode;
  endproperty
  a_ref_pci: assert property (p_ref_pci) else $error("PLL reference not PCI in agent mode");
  property p_factors;
    table_valid && $past(mode_code) == 7'h5c |-> comm_mult_x2 == 5'h05 && cpu_mult_x2 == 5'h08;
  endproperty
  a_factors: assert property (p_factors) else $error("mode 5c factors wrong");
  property p_apb_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB ready timing wrong");

  c_capture: cover property (!power_on_reset_input_n ##1 power_on_reset_input_n ##1 state == ST_RUN);
  c_tick: cover property (pci_clock_tick && gap_armed);
  c_reserved: cover property (mode_reserved && state == ST_RUN);
  c_ctl_write: cover property (psel && penable && pwrite && paddr == CONTROL_OFFSET);
endmodule : clock_mode_config_decoder

// ==== strap_board_model.sv ====
// Board side of the decoder: mode straps and the hard reset configuration word.
// Assumes the bench asks for a setting and drives por_n; noise comes from the bench.
`timescale 1ns/1ns
module strap_board_model (
  input wire logic por_n,
  input wire logic req_host,
  input wire logic req_range,
  input wire logic [6:0] req_code,
  input wire logic [31:0] noise,
  output logic host_enable_strap,
  output logic [31:0] config_word,
  output logic [2:0] low_mode_straps
);
  // Requested setting is shown only during power-on reset; reserved codes with no table entry are requested too
  always_comb begin
    if (!por_n) begin
      host_enable_strap = req_host;
      config_word = {req_code[6:3], req_range, noise[26:0]};
      low_mode_straps = req_code[2:0];
    end else begin
      // Board keeps changing the lines; the decoder must ignore them
      host_enable_strap = ~req_host ^ noise[31];
      config_word = ~noise;
      low_mode_straps = noise[30:28];
    end
  end
endmodule : strap_board_model

// ==== tb_clock_mode_config_decoder.sv ====
// Self-checking bench for the clock mode configuration decoder.
// Assumes a 25 MHz clock, an APB master task and the board strap model beside it.
`timescale 1ns/1ns
module tb_clock_mode_config_decoder;
  import clk_cfg_pkg::*;
  typedef struct {logic [31:0] data; logic err; logic chk;} exp_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por_n = 1'b1;
  logic req_host = 1'b0;
  logic req_range = 1'b0;
  logic [6:0] req_code = 7'h00;
  logic [31:0] noise = 32'h0000_0000;
  logic [31:0] seed = 32'h0001_7073;
  logic host_enable_strap;
  logic [31:0] config_word;
  logic [2:0] low_mode_straps;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, clocking_agent_mode, pci_range_select_bit, pll_ref_is_pci;
  logic [MODE_W-1:0] mode_code;
  logic mode_reserved, table_valid, pci_clock_tick;
  logic [FACTOR_W-1:0] comm_mult_x2, cpu_mult_x2;
  logic [DIV_W-1:0] pci_divider_field, pci_clock_ratio;
  int miscompares = 0;
  int n_tests = 0;
  int nt;
  exp_t expq[$];
  exp_t e;
  // Host range-1 cases: code, twice the factors, divider field, ratio, reserved
  logic [6:0] codes[8] = '{7'h00, 7'h02, 7'h10, 7'h18, 7'h46, 7'h5c, 7'h20, 7'h48};
  logic [4:0] comm_tab[8] = '{5'h04, 5'h05, 5'h08, 5'h0a, 5'h06, 5'h05, 5'h00, 5'h00};
  logic [4:0] cpu_tab[8] = '{5'h05, 5'h06, 5'h0a, 5'h0a, 5'h0d, 5'h08, 5'h00, 5'h00};
  logic [3:0] fld_tab[8] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'h7, 4'h7, 4'h0, 4'h0};
  logic [3:0] rat_tab[8] = '{4'h4, 4'h6, 4'h8, 4'h5, 4'h8, 4'h8, 4'h0, 4'h0};
  logic rsv_tab[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  // Free-running 25 MHz bus clock, far below the 133 MHz case, so no bus-mode settings apply
  always #20 clk = ~clk;

  strap_board_model strap_board_model_i (.por_n(por_n), .req_host(req_host), .req_range(req_range),
    .req_code(req_code), .noise(noise), .host_enable_strap(host_enable_strap),
    .config_word(config_word), .low_mode_straps(low_mode_straps));

  clock_mode_config_decoder clock_mode_config_decoder_i (.clk(clk), .rst(rst),
    .power_on_reset_input_n(por_n), .host_enable_strap(host_enable_strap), .config_word(config_word),
    .low_mode_straps(low_mode_straps), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clocking_agent_mode(clocking_agent_mode), .pci_range_select_bit(pci_range_select_bit),
    .pll_ref_is_pci(pll_ref_is_pci), .mode_code(mode_code), .mode_reserved(mode_reserved),
    .table_valid(table_valid), .comm_mult_x2(comm_mult_x2), .cpu_mult_x2(cpu_mult_x2),
    .pci_divider_field(pci_divider_field), .pci_clock_ratio(pci_clock_ratio),
    .pci_clock_tick(pci_clock_tick));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // APB transfer; the expected answer is noted before the request goes out
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [31:0] xd, input logic xe);
    expq.push_back('{data: xd, err: xe, chk: ~wr});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Power-on reset with a requested setting, then the board scrambles its lines
  task automatic cfg(input logic h, input logic r, input logic [6:0] c);
    @(posedge clk);
    req_host <= h;
    req_range <= r;
    req_code <= c;
    por_n <= 1'b0;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    repeat (4) begin
      @(posedge clk);
      seed = lfsr_next(seed);
      noise <= seed;
    end
  endtask : cfg

  task automatic count_ticks(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (pci_clock_tick === 1'b1) n++;
    end
  endtask : count_ticks

  // Monitor: each completed APB transfer is matched to the oldest note
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (expq.size() == 0) begin
        check(prdata, 32'hffff_ffff);
      end else begin
        e = expq.pop_front();
        check({31'h0, pslverr}, {31'h0, e.err});
        if (e.chk) check(prdata, e.data);
      end
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({25'h0, mode_code}, 32'h0);
    apb(1'b0, STATUS_OFFSET, 32'h0, 32'h0, 1'b0);
    apb(1'b0, CONTROL_OFFSET, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    seed = lfsr_next(seed);
    apb(1'b1, STATUS_OFFSET, seed, 32'h0, 1'b0);
    apb(1'b1, 8'h10, seed, 32'h0, 1'b1);
    apb(1'b0, STATUS_OFFSET, 32'h0, 32'h0, 1'b0);
    // Host mode, 25-50 MHz range, every table case
    for (int i = 0; i < 8; i++) begin
      cfg(1'b0, 1'b1, codes[i]);
      apb(1'b0, STATUS_OFFSET, 32'h0, (rsv_tab[i] ? 32'h2a : 32'h32) | {17'h0, codes[i], 8'h00}, 1'b0);
      check({31'h0, mode_reserved}, {31'h0, rsv_tab[i]});
      if (!rsv_tab[i]) begin
        apb(1'b0, FACTOR_OFFSET, 32'h0, {4'h0, rat_tab[i], 4'h0, fld_tab[i], 3'h0, cpu_tab[i], 3'h0,
            comm_tab[i]}, 1'b0);
        check({28'h0, pci_clock_ratio}, {28'h0, rat_tab[i]});
        count_ticks(120, nt);
        check(nt, 120 / int'(rat_tab[i]));
      end
    end
    // Agent mode takes the PCI clock as reference
    cfg(1'b1, 1'b1, 7'h00);
    apb(1'b0, STATUS_OFFSET, 32'h0, 32'h27, 1'b0);
    check({30'h0, clocking_agent_mode, pll_ref_is_pci}, 32'h3);
    // Host mode, 50-66 MHz range
    cfg(1'b0, 1'b0, 7'h00);
    apb(1'b0, STATUS_OFFSET, 32'h0, 32'h20, 1'b0);
    check({27'h0, pci_range_select_bit, pci_clock_ratio}, 32'h0);
    // Tick enable off and on again
    cfg(1'b0, 1'b1, 7'h00);
    seed = lfsr_next(seed);
    apb(1'b1, CONTROL_OFFSET, {seed[31:1], 1'b0}, 32'h0, 1'b0);
    apb(1'b0, CONTROL_OFFSET, 32'h0, 32'h0, 1'b0);
    count_ticks(40, nt);
    check(nt, 0);
    apb(1'b1, CONTROL_OFFSET, 32'h1, 32'h0, 1'b0);
    apb(1'b0, CONTROL_OFFSET, 32'h0, 32'h1, 1'b0);
    count_ticks(40, nt);
    check(nt, 10);
    // Second reset in mid-run clears the captured setting
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, STATUS_OFFSET, 32'h0, 32'h0, 1'b0);
    check({31'h0, table_valid}, 32'h0);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : tb_clock_mode_config_decoder
